// ### design/stl_pkg.sv
package stl_pkg;
   // Control loop timing
   localparam int CLK_HZ = 20_000_000;
   localparam int LOOP_PERIOD_US = 1000;
   localparam int LOOP_CYCLES = (CLK_HZ / 1_000_000) * LOOP_PERIOD_US;
   localparam int LOOP_MS = 1;

   // Link type codes seen on the step interface
   localparam logic [7:0] LT_TIMER_START_OR_EXPIRED = 8'h54;
   localparam logic [7:0] LT_TIMER_NOT_EXPIRED = 8'h74;
   localparam logic [7:0] LT_WAIT_BITS = 8'h57;

   localparam int TIMER_W = 16;
   localparam logic [TIMER_W-1:0] TIMER_MAX = 16'hffff;
   localparam logic [15:0] PRESET_START = 16'h0000;
   localparam int WAIT_W = 8;
   localparam int WAIT_SET_LSB = 0;
   localparam int WAIT_CLR_LSB = 8;
   localparam int AXIS_W = 2;

   // Register byte offsets
   localparam logic [7:0] REG_WAIT_SET = 8'h00;
   localparam logic [7:0] REG_WAIT_CLR = 8'h04;
   localparam logic [7:0] REG_WAIT_BITS = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_TIMER_SEL = 8'h10;
   localparam logic [7:0] REG_TIMER_VAL = 8'h14;

   // Status register fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_RES_LSB = 1;
   localparam int ST_AXIS_LSB = 4;
   localparam logic [7:0] WAIT_RESET = 8'h00;

   typedef enum logic [2:0] {
      K_START = 3'h0,
      K_EXPIRED = 3'h1,
      K_NOT_EXPIRED = 3'h2,
      K_WAIT_BITS = 3'h3,
      K_OTHER = 3'h4
   } stl_kind_t;

   typedef enum logic [1:0] {
      RES_NONE = 2'h0,
      RES_LINK_NEXT = 2'h1,
      RES_SEQ_NEXT = 2'h2,
      RES_UNSUPPORTED = 2'h3
   } stl_res_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EVAL = 2'b01,
      ST_RESP = 2'b11
   } stl_state_t;

   typedef struct packed {
      logic [7:0] link_type;
      logic [15:0] link_value;
      logic [AXIS_W-1:0] axis;
      logic poll;
   } stl_req_t;

   typedef struct packed {
      stl_res_t res;
      logic [AXIS_W-1:0] axis;
   } stl_rsp_t;
endpackage

// ### design/stl_link_eval.sv
`timescale 1ns/10ps
// Summary of operation
// - Timer start link with value zero restarts axis timer, takes Link Next at once.
// - Timer expired link without polling waits until timer reaches preset, then Link Next.
// - Polled expired link: Link Next if expired, else the following step.
// - Polled not-expired link: Link Next while below preset, else following step.
// - Expired means elapsed count at or above preset.
// - Every evaluated step consumes one control loop period.
// - Two-step polling loop evaluates each condition once per two loops.
// - Wait-bit link code selects wait-bit mask evaluation.
// - Upper byte names bits needing zero, lower byte bits needing one.
// - Link Next only when all named set bits one and clear bits zero.
// - Command writes and spline processor writes modify the same wait bits.
// - One step timer per axis, separate from the fixed delay timer.
// - Expiry may be decided up to one control loop late.
module stl_link_eval #(
   parameter int NUM_AXES = 4,
   parameter int LOOP_MS = stl_pkg::LOOP_MS,
   parameter int LOOP_CYCLES = stl_pkg::LOOP_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic req_valid,
   input wire stl_pkg::stl_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output stl_pkg::stl_rsp_t rsp,
   input wire logic rsp_ready,
   input wire logic [7:0] spline_set,
   input wire logic [7:0] spline_clr,
   output logic [7:0] wait_bits,
   output logic loop_tick,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   // Counter wide enough to hold a whole loop of clock cycles
   localparam int LC_W = $clog2(LOOP_CYCLES + 1);
   localparam int TW = stl_pkg::TIMER_W;

   stl_pkg::stl_state_t state_r;
   stl_pkg::stl_kind_t kind_r;
   logic [LC_W-1:0] loop_cnt_r;
   logic loop_tick_r;
   logic [TW-1:0] timer_r [NUM_AXES];
   logic [15:0] preset_r;
   logic [stl_pkg::AXIS_W-1:0] axis_r;
   logic poll_r;
   logic [7:0] wait_bits_r;
   logic [stl_pkg::AXIS_W-1:0] timer_sel_r;
   logic req_ready_r;
   logic rsp_valid_r;
   stl_pkg::stl_rsp_t rsp_r;
   stl_pkg::stl_res_t last_res_r;
   logic [31:0] readdata_r;
   logic waitreq_r;
   logic req_fire;
   logic bus_wr;
   logic [TW-1:0] cur_timer;
   logic expired;
   logic wait_ok;
   logic eval_done;
   stl_pkg::stl_res_t eval_res;
   logic restart;

   // Link type code to evaluation kind
   function automatic stl_pkg::stl_kind_t link_kind(input logic [7:0] ltype, input logic [15:0] lval);
      stl_pkg::stl_kind_t k;
      k = stl_pkg::K_OTHER;
      if (ltype == stl_pkg::LT_TIMER_START_OR_EXPIRED) begin
         k = (lval == stl_pkg::PRESET_START) ? stl_pkg::K_START : stl_pkg::K_EXPIRED;
      end else if (ltype == stl_pkg::LT_TIMER_NOT_EXPIRED) begin
         k = stl_pkg::K_NOT_EXPIRED;
      end else if (ltype == stl_pkg::LT_WAIT_BITS) begin
         k = stl_pkg::K_WAIT_BITS;
      end
      return k;
   endfunction

   assign req_fire = req_valid && req_ready_r;
   // A write lands only at the edge where waitrequest is already low
   assign bus_wr = avs_write && !waitreq_r;
   // Count before this tick adds to it, so expiry may be one loop late
   assign cur_timer = timer_r[axis_r];
   // Reaching the preset counts as expired, not only passing it
   assign expired = cur_timer >= preset_r;
   // Upper byte must read zero, lower byte must read one
   assign wait_ok = ((wait_bits_r & preset_r[stl_pkg::WAIT_SET_LSB +: 8]) == preset_r[stl_pkg::WAIT_SET_LSB +: 8])
      && ((wait_bits_r & preset_r[stl_pkg::WAIT_CLR_LSB +: 8]) == 8'h00);
   // Restart only at the tick that answers the start step
   assign restart = (state_r == stl_pkg::ST_EVAL) && loop_tick_r && (kind_r == stl_pkg::K_START);

   // Control loop tick; the step decision only happens on it
   always_ff @(posedge clock) begin
      if (rst) begin
         loop_cnt_r <= '0;
         loop_tick_r <= 1'b0;
      end else if (loop_cnt_r == LC_W'(LOOP_CYCLES - 1)) begin
         loop_cnt_r <= '0;
         loop_tick_r <= 1'b1;
      end else begin
         loop_cnt_r <= loop_cnt_r + 1'b1;
         loop_tick_r <= 1'b0;
      end
   end

   // Step decision for the loop tick in progress
   always_comb begin
      eval_done = 1'b0;
      eval_res = stl_pkg::RES_NONE;
      unique case (kind_r)
         stl_pkg::K_START: begin
            eval_done = 1'b1;
            eval_res = stl_pkg::RES_LINK_NEXT;
         end
         stl_pkg::K_EXPIRED: begin
            eval_done = expired || poll_r;
            eval_res = expired ? stl_pkg::RES_LINK_NEXT : stl_pkg::RES_SEQ_NEXT;
         end
         stl_pkg::K_NOT_EXPIRED: begin
            // Without polling this waits for a timer to go back, only a restart does that
            eval_done = !expired || poll_r;
            eval_res = !expired ? stl_pkg::RES_LINK_NEXT : stl_pkg::RES_SEQ_NEXT;
         end
         stl_pkg::K_WAIT_BITS: begin
            eval_done = wait_ok || poll_r;
            eval_res = wait_ok ? stl_pkg::RES_LINK_NEXT : stl_pkg::RES_SEQ_NEXT;
         end
         stl_pkg::K_OTHER: begin
            eval_done = 1'b1;
            eval_res = stl_pkg::RES_UNSUPPORTED;
         end
      endcase
   end

   // Step sequencing: accept, decide on a loop tick, answer
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= stl_pkg::ST_IDLE;
         req_ready_r <= 1'b1;
         rsp_valid_r <= 1'b0;
         rsp_r <= '0;
         kind_r <= stl_pkg::K_OTHER;
         preset_r <= '0;
         axis_r <= '0;
         poll_r <= 1'b0;
         last_res_r <= stl_pkg::RES_NONE;
      end else begin
         unique case (state_r)
            stl_pkg::ST_IDLE: begin
               if (req_fire) begin
                  // Latch the whole step; the sequencer may drop its lines once taken
                  kind_r <= link_kind(req.link_type, req.link_value);
                  preset_r <= req.link_value;
                  axis_r <= req.axis;
                  poll_r <= req.poll;
                  req_ready_r <= 1'b0;
                  state_r <= stl_pkg::ST_EVAL;
               end
            end
            stl_pkg::ST_EVAL: begin
               // One loop per step, so a two-step poll sees each test every second loop
               if (loop_tick_r && eval_done) begin
                  rsp_valid_r <= 1'b1;
                  rsp_r.res <= eval_res;
                  rsp_r.axis <= axis_r;
                  last_res_r <= eval_res;
                  state_r <= stl_pkg::ST_RESP;
               end
            end
            stl_pkg::ST_RESP: begin
               // Answer stands until the sequencer takes it
               if (rsp_ready) begin
                  rsp_valid_r <= 1'b0;
                  req_ready_r <= 1'b1;
                  state_r <= stl_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // Per-axis step timers, distinct from any fixed delay timer
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < NUM_AXES; i++) begin
            timer_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_AXES; i++) begin
            if (restart && (axis_r == stl_pkg::AXIS_W'(i))) begin
               timer_r[i] <= '0;
            end else if (loop_tick_r) begin
               // Saturate so an expired timer stays expired
               if (timer_r[i] > stl_pkg::TIMER_MAX - TW'(LOOP_MS)) begin
                  timer_r[i] <= stl_pkg::TIMER_MAX;
               end else begin
                  timer_r[i] <= timer_r[i] + TW'(LOOP_MS);
               end
            end
         end
      end
   end

   // Wait bits: set wins over clear when both writers collide
   // A bit set and cleared in one cycle ends up set, whichever writer clears it
   always_ff @(posedge clock) begin
      if (rst) begin
         wait_bits_r <= stl_pkg::WAIT_RESET;
      end else begin
         wait_bits_r <= (wait_bits_r
            & ~spline_clr
            & ~((bus_wr && avs_address == stl_pkg::REG_WAIT_CLR && avs_byteenable[0]) ? avs_writedata[7:0] : 8'h00))
            | spline_set
            | ((bus_wr && avs_address == stl_pkg::REG_WAIT_SET && avs_byteenable[0]) ? avs_writedata[7:0] : 8'h00);
      end
   end

   // Timer readback select
   always_ff @(posedge clock) begin
      if (rst) begin
         timer_sel_r <= '0;
      end else if (bus_wr && avs_address == stl_pkg::REG_TIMER_SEL && avs_byteenable[0]) begin
         timer_sel_r <= avs_writedata[stl_pkg::AXIS_W-1:0];
      end
   end

   // Bus answer one cycle after the request; unmapped reads give zero
   always_ff @(posedge clock) begin
      if (rst) begin
         waitreq_r <= 1'b1;
         readdata_r <= '0;
      end else begin
         waitreq_r <= !((avs_read || avs_write) && waitreq_r);
         if (avs_read && waitreq_r) begin
            unique case (avs_address)
               stl_pkg::REG_WAIT_BITS: readdata_r <= {24'h000000, wait_bits_r};
               // Busy, last answer and last axis
               stl_pkg::REG_STATUS: begin
                  readdata_r <= '0;
                  readdata_r[stl_pkg::ST_BUSY_BIT] <= !req_ready_r;
                  readdata_r[stl_pkg::ST_RES_LSB +: 2] <= last_res_r;
                  readdata_r[stl_pkg::ST_AXIS_LSB +: stl_pkg::AXIS_W] <= axis_r;
               end
               stl_pkg::REG_TIMER_SEL: readdata_r <= {30'h00000000, timer_sel_r};
               stl_pkg::REG_TIMER_VAL: readdata_r <= {16'h0000, timer_r[timer_sel_r]};
               default: readdata_r <= '0;
            endcase
         end
      end
   end

   // Outputs straight from their registers
   assign req_ready = req_ready_r;
   assign rsp_valid = rsp_valid_r;
   assign rsp = rsp_r;
   assign wait_bits = wait_bits_r;
   assign loop_tick = loop_tick_r;
   assign avs_readdata = readdata_r;
   assign avs_waitrequest = waitreq_r;

   // Checks on the step decisions
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   start_links_a: assert property ($rose(rsp_valid_r) && kind_r == stl_pkg::K_START
      |-> rsp_r.res == stl_pkg::RES_LINK_NEXT && timer_r[axis_r] == '0)
      else $error("timer start did not restart and link");
   hold_wait_a: assert property (state_r == stl_pkg::ST_EVAL && !poll_r && kind_r == stl_pkg::K_EXPIRED
      && loop_tick_r && cur_timer < preset_r |=> state_r == stl_pkg::ST_EVAL && !rsp_valid_r)
      else $error("unpolled timer link left before preset");
   poll_expired_a: assert property ($rose(rsp_valid_r) && kind_r == stl_pkg::K_EXPIRED && poll_r
      |-> rsp_r.res == (($past(cur_timer) >= preset_r) ? stl_pkg::RES_LINK_NEXT : stl_pkg::RES_SEQ_NEXT))
      else $error("polled expired link wrong branch");
   poll_not_exp_a: assert property ($rose(rsp_valid_r) && kind_r == stl_pkg::K_NOT_EXPIRED && poll_r
      |-> rsp_r.res == (($past(cur_timer) < preset_r) ? stl_pkg::RES_LINK_NEXT : stl_pkg::RES_SEQ_NEXT))
      else $error("polled not-expired link wrong branch");
   expire_equal_a: assert property (state_r == stl_pkg::ST_EVAL && kind_r == stl_pkg::K_EXPIRED
      && loop_tick_r && cur_timer == preset_r |=> rsp_valid_r && rsp_r.res == stl_pkg::RES_LINK_NEXT)
      else $error("timer equal to preset not expired");
   loop_per_step_a: assert property ($rose(rsp_valid_r) |-> $past(loop_tick_r))
      else $error("step answered off the loop tick");
   wait_match_a: assert property ($rose(rsp_valid_r) && kind_r == stl_pkg::K_WAIT_BITS
      |-> (rsp_r.res == stl_pkg::RES_LINK_NEXT) == $past(wait_ok))
      else $error("wait bit link decision wrong");
   spline_set_a: assert property (spline_set != 8'h00
      |=> (wait_bits_r & $past(spline_set)) == $past(spline_set))
      else $error("spline set lost");
   timer_step_a: assert property (loop_tick_r && !restart && timer_r[0] < stl_pkg::TIMER_MAX - TW'(LOOP_MS)
      |=> timer_r[0] == $past(timer_r[0]) + TW'(LOOP_MS))
      else $error("timer did not advance one loop");
   saturate_a: assert property (timer_r[0] == stl_pkg::TIMER_MAX && !restart
      |=> timer_r[0] == stl_pkg::TIMER_MAX)
      else $error("timer wrapped");
   // Bus slave always answers after exactly one wait state
   bus_answer_a: assert property ((avs_read || avs_write) && waitreq_r |=> !waitreq_r)
      else $error("bus answer late");

   // Each axis keeps its own count; a restart elsewhere must not touch axis zero
   axis_timer_a: assert property (restart && axis_r != '0
      && timer_r[0] < stl_pkg::TIMER_MAX - TW'(LOOP_MS)
      |=> timer_r[0] == $past(timer_r[0]) + TW'(LOOP_MS))
      else $error("restart leaked to another axis");
   // Polled steps never hold, so a two-step loop sees each test every second tick
   poll_one_tick_a: assert property (state_r == stl_pkg::ST_EVAL && poll_r && loop_tick_r
      |=> rsp_valid_r)
      else $error("polled step held past its tick");
   tick_pulse_a: assert property (loop_tick_r |=> !loop_tick_r)
      else $error("loop tick longer than one cycle");
   // Wait-bit code must reach the mask decoder, whatever the value
   wait_code_a: assert property (req_fire && req.link_type == stl_pkg::LT_WAIT_BITS
      |=> kind_r == stl_pkg::K_WAIT_BITS)
      else $error("wait bit code not decoded");
   // Unpolled wait-bit step stays put until the mask matches
   wait_hold_a: assert property (state_r == stl_pkg::ST_EVAL && !poll_r && kind_r == stl_pkg::K_WAIT_BITS
      && loop_tick_r && !wait_ok |=> state_r == stl_pkg::ST_EVAL && !rsp_valid_r)
      else $error("unpolled wait bit link left early");
   // Both writers reach the same bits; a clear with no set alongside must stick
   spline_clr_a: assert property (spline_clr != 8'h00 && spline_set == 8'h00
      && !(bus_wr && avs_address == stl_pkg::REG_WAIT_SET)
      |=> (wait_bits_r & $past(spline_clr)) == 8'h00)
      else $error("spline clear lost");
   bus_set_a: assert property (bus_wr && avs_address == stl_pkg::REG_WAIT_SET && avs_byteenable[0]
      |=> (wait_bits_r & 8'($past(avs_writedata))) == 8'($past(avs_writedata)))
      else $error("bus set of wait bits lost");

   // Main scenarios worth seeing in a run
   start_seen_c: cover property ($rose(rsp_valid_r) && kind_r == stl_pkg::K_START);
   poll_seq_c: cover property ($rose(rsp_valid_r) && rsp_r.res == stl_pkg::RES_SEQ_NEXT);
   wait_link_c: cover property ($rose(rsp_valid_r) && kind_r == stl_pkg::K_WAIT_BITS
      && rsp_r.res == stl_pkg::RES_LINK_NEXT);
   held_step_c: cover property (state_r == stl_pkg::ST_EVAL && loop_tick_r && !eval_done);
   hold_expired_c: cover property (state_r == stl_pkg::ST_EVAL && !poll_r && kind_r == stl_pkg::K_EXPIRED
      && loop_tick_r && !expired);
endmodule

// ### tb/stl_seq_model.sv
`timescale 1ns/10ps
// Sequencer stand-in: offers one step at a time, counts loop ticks, takes the answer
module stl_seq_model (
   input wire logic clock,
   output logic req_valid,
   output stl_pkg::stl_req_t req,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire stl_pkg::stl_rsp_t rsp,
   output logic rsp_ready,
   input wire logic loop_tick
);
   int stall = 0; // Extra cycles before taking an answer, a slow sequencer

   // Idle at time zero
   initial begin
      req_valid = 1'b0;
      req = '0;
      rsp_ready = 1'b0;
   end

   // Upper case code starts or tests expiry, lower case tests not-expired
   // Preset 1 to 65535 ms, zero only to start
   task automatic step(input logic [7:0] lt, input logic [15:0] lv, input logic [1:0] ax, input logic pl,
                       output stl_pkg::stl_rsp_t r, output int ticks);
      ticks = 0;
      @(posedge clock);
      req_valid <= 1'b1;
      req <= '{lt, lv, ax, pl};
      do @(posedge clock); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      req <= ~req; // Released lines must not keep the old step
      while (rsp_valid !== 1'b1) begin
         @(posedge clock);
         if (loop_tick === 1'b1) ticks++;
      end
      r = rsp;
      repeat (stall) @(posedge clock);
      rsp_ready <= 1'b1;
      @(posedge clock);
      rsp_ready <= 1'b0;
   endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic clock, rst, req_valid, req_ready, rsp_valid, rsp_ready, loop_tick;
   stl_pkg::stl_req_t req;
   stl_pkg::stl_rsp_t rsp;
   logic [7:0] spline_set, spline_clr, wait_bits, avs_address;
   logic avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   int err_count = 0;
   int comparisons = 0;
   // Short loop so a saturation run stays cheap; 1000 ms added per tick
   stl_link_eval #(.NUM_AXES(4), .LOOP_MS(1000), .LOOP_CYCLES(20)) dut (.clock(clock), .rst(rst),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .rsp_ready(rsp_ready), .spline_set(spline_set), .spline_clr(spline_clr), .wait_bits(wait_bits),
      .loop_tick(loop_tick), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   stl_seq_model seq (.clock(clock), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready), .loop_tick(loop_tick));

   // Clock
   always #25 clock = ~clock;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      if (err_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Avalon write, held until waitrequest is sampled low
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask

   // One step through the sequencer, answer and loop count compared
   task automatic run(input logic [7:0] lt, input logic [15:0] lv, input logic [1:0] ax, input logic pl,
                      input logic [1:0] er, input int tmin, input int tmax);
      stl_pkg::stl_rsp_t r;
      int n;
      seq.step(lt, lv, ax, pl, r, n);
      chk(32'(r.res), 32'(er));
      chk(32'(r.axis), 32'(ax));
      chk(32'(n >= tmin && n <= tmax), 32'h1);
   endtask

   // One-cycle spline pulse on the set or clear mask
   task automatic spline(input logic [7:0] s, input logic [7:0] c);
      @(posedge clock);
      spline_set <= s;
      spline_clr <= c;
      @(posedge clock);
      spline_set <= 8'h00;
      spline_clr <= 8'h00;
      @(posedge clock);
   endtask

   // Mask cases against wait bits 0x18: value and expected answer
   localparam logic [15:0] WV [7] = '{16'h0008, 16'h0018, 16'h0000, 16'h0001, 16'h0800, 16'h2018, 16'h0818};
   localparam logic [1:0] WR [7] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2};

   // Hang guard, well past the expected run length
   initial begin
      #(30000 * 50);
      err_count++;
      wrap_up();
   end

   // Main sequence
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      spline_set = 8'h00;
      spline_clr = 8'h00;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk(32'(req_ready), 32'h1);
      chk(32'(rsp_valid), 32'h0);
      chk(32'(wait_bits), 32'h0);
      bus_wr(stl_pkg::REG_WAIT_SET, 32'h0000000f);
      bus_rd(stl_pkg::REG_WAIT_BITS, rd);
      chk(rd, 32'h0000000f);
      spline(8'h00, 8'h03);
      chk(32'(wait_bits), 32'h0c);
      bus_wr(stl_pkg::REG_WAIT_CLR, 32'h00000004);
      spline(8'h10, 8'h00);
      bus_rd(stl_pkg::REG_WAIT_BITS, rd);
      chk(rd, 32'h00000018);
      bus_rd(8'h40, rd);
      chk(rd, 32'h0);
      for (int i = 0; i < 7; i++) begin
         run(stl_pkg::LT_WAIT_BITS, WV[i], 2'(i), 1'b1, WR[i], 1, 1);
      end
      // Unpolled wait-bit link that already matches is answered at the first tick
      run(stl_pkg::LT_WAIT_BITS, 16'h2018, 2'h0, 1'b0, 2'h1, 1, 1);
      run(stl_pkg::LT_TIMER_START_OR_EXPIRED, 16'h0000, 2'h1, 1'b0, 2'h1, 1, 1);
      run(stl_pkg::LT_TIMER_START_OR_EXPIRED, 16'h0bb8, 2'h1, 1'b1, 2'h2, 1, 1);
      run(stl_pkg::LT_TIMER_NOT_EXPIRED, 16'h0bb8, 2'h1, 1'b1, 2'h1, 1, 1);
      // Unpolled not-expired link while the count is still 2000
      run(stl_pkg::LT_TIMER_NOT_EXPIRED, 16'h0bb8, 2'h1, 1'b0, 2'h1, 1, 1);
      run(stl_pkg::LT_TIMER_START_OR_EXPIRED, 16'h0000, 2'h1, 1'b0, 2'h1, 1, 1);
      run(stl_pkg::LT_TIMER_START_OR_EXPIRED, 16'h0bb8, 2'h1, 1'b0, 2'h1, 2, 4);
      run(stl_pkg::LT_TIMER_START_OR_EXPIRED, 16'h0bb8, 2'h1, 1'b1, 2'h1, 1, 1);
      run(stl_pkg::LT_TIMER_NOT_EXPIRED, 16'h0bb8, 2'h1, 1'b1, 2'h2, 1, 1);
      run(stl_pkg::LT_TIMER_START_OR_EXPIRED, 16'h0000, 2'h0, 1'b0, 2'h1, 1, 1);
      run(stl_pkg::LT_TIMER_START_OR_EXPIRED, 16'h0bb8, 2'h0, 1'b1, 2'h2, 1, 1);
      run(stl_pkg::LT_TIMER_START_OR_EXPIRED, 16'h0bb8, 2'h1, 1'b1, 2'h1, 1, 1);
      run(stl_pkg::LT_TIMER_START_OR_EXPIRED, 16'h0, 2'h3, 1'b0, 2'h1, 1, 1);
      // 70 loops push 70000 ms past the 16-bit top; a wrapped count would read low
      repeat (70 * 20) @(posedge clock);
      run(stl_pkg::LT_TIMER_START_OR_EXPIRED, 16'hffff, 2'h3, 1'b1, 2'h1, 1, 1);
      bus_wr(stl_pkg::REG_TIMER_SEL, 32'h00000003);
      bus_rd(stl_pkg::REG_TIMER_VAL, rd);
      chk(rd, 32'h0000ffff);
      seq.stall = 5;
      run(8'h42, 16'h0005, 2'h2, 1'b1, 2'h3, 1, 1);
      bus_rd(stl_pkg::REG_STATUS, rd);
      chk(rd, 32'h00000026);
      wrap_up();
   end
endmodule
